// File: src/srs_pkg.sv
// Purpose: Shared constants for the serial memory read sequencer and its bus master
// Assumes: One system clock at 25 MHz; two-wire bus clock made by the master end
// Notes: Select code layout and timing divider live here
package srs_pkg;
   localparam int SRS_ADDR_W = 16;
   localparam int SRS_MEM_DEPTH_LOG2 = 8;
   localparam logic [6:0] SRS_SEL_CODE = 7'h54;
   localparam logic SRS_DIR_READ = 1'b1;
   localparam logic SRS_DIR_WRITE = 1'b0;
   localparam logic [7:0] SRS_ERASED = 8'hff;
   localparam int SRS_BIT_LAST = 7;
   localparam int SRS_CLK_HZ = 25000000;
   localparam int SRS_SCL_HZ = 400000;
   // Quarter period of the bus clock, rounded down so the bus runs no slower than asked
   localparam int SRS_QTR_CYC = SRS_CLK_HZ / (4 * SRS_SCL_HZ);
   localparam int SRS_FIFO_DEPTH = 8;
   typedef enum logic [1:0] {SRS_OP_CUR, SRS_OP_RAND, SRS_OP_NONE} srs_op_e;
endpackage

// File: src/srs_link_if.sv
// Purpose: Two-wire link between master end and memory end
// Assumes: Open-drain wires resolved here from the enables
// Notes: Master end sees both pins as input, output and output enable; memory end sees the clock as input only
`timescale 1ns/10ps
interface srs_link_if;
   logic scl_oe;
   logic scl_out;
   logic m_sda_oe;
   logic m_sda_out;
   logic s_sda_oe;
   logic s_sda_out;
   logic scl;
   logic sda;
   // Wired-AND with pull-up
   assign scl = !(scl_oe && !scl_out);
   assign sda = !((m_sda_oe && !m_sda_out) || (s_sda_oe && !s_sda_out));
   modport master (output scl_oe, output scl_out, output m_sda_oe, output m_sda_out, input scl, input sda);
   modport memory (output s_sda_oe, output s_sda_out, input scl, input sda);
endinterface

// File: src/srs_mem.sv
// Purpose: Serial memory end: select decode, address load and read stream
// Assumes: Bus clock and data reach it as pins, sampled on mclk_i
// Notes: Write data bytes are acknowledged but not stored; only reads are served
//
// Summary of operation
// R1: Counter advances by one after each read
// R2: Release data, sample master acknowledge on ninth bit
// R3: Missing acknowledge ends output, back to standby
// R4: Master loads address by write, no stop
// R5: Master repeats start with read select
// R6: Acknowledge read select, send addressed byte
// R7: Single random read: master no-acks, stops
// R8: Current read returns counter byte, then increments
// R9: Current read ends with no-ack and stop
// R10: Master should prefer random over current read
// R11: Acknowledged byte continues with next byte
// R12: Stream ends with no-ack then stop
// R13: Sequential bytes come from consecutive addresses
// R14: Counter wraps from top to zero
// R15: Array starts with every byte all ones
// R16: Select sent MSB first, last bit direction
// R17: After write select, two acknowledged address bytes
// R18: Mismatched select: no acknowledge, standby
// R19: One counter, modulo array size
`timescale 1ns/10ps
module srs_mem
   import srs_pkg::*;
#(
   parameter int AW = SRS_MEM_DEPTH_LOG2
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Link
   srs_link_if.memory link,
   // Status
   output logic busy_o,
   output logic [AW-1:0] addr_o
);
   import srs_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_ADRH, ST_ADRL, ST_WDAT, ST_RD, ST_RACK} srs_mst_e;

   logic [7:0] mem [0:(1<<AW)-1];
   logic scl_m_ff, scl_s_ff, scl_d_ff;
   logic sda_m_ff, sda_s_ff, sda_d_ff;
   srs_mst_e st_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sh_ff;
   logic ack_ff;
   logic sda_oe_ff;
   logic [AW-1:0] addr_ff;
   logic busy_ff;

   initial
   begin
      for (int i = 0; i < (1<<AW); i++)
      begin
         mem[i] = SRS_ERASED; // R15
      end
   end

   wire scl_rise = scl_s_ff && !scl_d_ff;
   wire scl_fall = !scl_s_ff && scl_d_ff;
   wire start_det = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
   wire stop_det = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;
   wire [7:0] rx_byte = {sh_ff[6:0], sda_s_ff};
   wire sel_hit = (rx_byte[7:1] == SRS_SEL_CODE); // R18
   wire [AW-1:0] addr_inc = addr_ff + 1'b1; // R14 R19
   wire [7:0] rd_byte = mem[addr_ff];

   assign link.s_sda_oe = sda_oe_ff;
   assign link.s_sda_out = 1'b0;
   assign busy_o = busy_ff;
   assign addr_o = addr_ff;

   always_ff @(posedge mclk_i)
   begin
      scl_m_ff <= link.scl;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= link.sda;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         st_ff <= ST_IDLE;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         ack_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         addr_ff <= '0;
         busy_ff <= 1'b0;
      end
      else if (start_det)
      begin
         st_ff <= ST_SEL;
         cnt_ff <= 4'h0;
         ack_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         busy_ff <= 1'b1;
      end
      else if (stop_det)
      begin
         st_ff <= ST_IDLE;
         sda_oe_ff <= 1'b0;
         busy_ff <= 1'b0;
      end
      else
      begin
         case (st_ff)
            ST_IDLE:
            begin
               sda_oe_ff <= 1'b0;
               busy_ff <= 1'b0;
            end
            ST_SEL, ST_ADRH, ST_ADRL, ST_WDAT:
            begin
               // Receive 8 bits MSB first, drive ack in ninth slot
               if (scl_rise && cnt_ff <= 4'(SRS_BIT_LAST))
               begin
                  sh_ff <= rx_byte; // R16
                  cnt_ff <= cnt_ff + 4'h1;
                  if (cnt_ff == 4'(SRS_BIT_LAST))
                  begin
                     ack_ff <= (st_ff != ST_SEL) || sel_hit;
                  end
               end
               else if (scl_fall && cnt_ff == 4'h8)
               begin
                  sda_oe_ff <= ack_ff; // R17 R18
                  cnt_ff <= 4'h9;
                  if (!ack_ff)
                  begin
                     st_ff <= ST_IDLE; // R18
                  end
               end
               else if (scl_fall && cnt_ff == 4'h9)
               begin
                  cnt_ff <= 4'h0;
                  case (st_ff)
                     ST_SEL:
                     begin
                        if (sh_ff[0] == SRS_DIR_READ)
                        begin
                           st_ff <= ST_RD; // R6 R8
                           sh_ff <= rd_byte;
                           sda_oe_ff <= !rd_byte[7];
                        end
                        else
                        begin
                           st_ff <= ST_ADRH; // R17
                           sda_oe_ff <= 1'b0;
                        end
                     end
                     ST_ADRH:
                     begin
                        // High byte lands above bit 7; it falls away when the array is 256 bytes
                        addr_ff <= AW'({sh_ff, 8'h00}); // R19
                        st_ff <= ST_ADRL;
                        sda_oe_ff <= 1'b0;
                     end
                     ST_ADRL:
                     begin
                        addr_ff <= addr_ff | AW'(sh_ff); // R19
                        st_ff <= ST_WDAT;
                        sda_oe_ff <= 1'b0;
                     end
                     default:
                     begin
                        st_ff <= ST_WDAT;
                        sda_oe_ff <= 1'b0;
                     end
                  endcase
               end
            end
            ST_RD:
            begin
               // Shift out on falling edges; bit 7 already driven
               if (scl_fall)
               begin
                  if (cnt_ff == 4'(SRS_BIT_LAST))
                  begin
                     sda_oe_ff <= 1'b0; // R2
                     addr_ff <= addr_inc; // R1 R8 R13 R14
                     st_ff <= ST_RACK;
                     cnt_ff <= 4'h0;
                  end
                  else
                  begin
                     sh_ff <= {sh_ff[6:0], 1'b1};
                     sda_oe_ff <= !sh_ff[6];
                     cnt_ff <= cnt_ff + 4'h1;
                  end
               end
            end
            ST_RACK:
            begin
               if (scl_rise)
               begin
                  ack_ff <= !sda_s_ff; // R2
               end
               else if (scl_fall)
               begin
                  if (ack_ff)
                  begin
                     st_ff <= ST_RD; // R11 R13
                     sh_ff <= rd_byte;
                     sda_oe_ff <= !rd_byte[7];
                  end
                  else
                  begin
                     st_ff <= ST_IDLE; // R3
                     sda_oe_ff <= 1'b0;
                  end
               end
            end
            default:
            begin
               st_ff <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// File: src/srs_master.sv
// Purpose: Bus master end: issues random or current address reads, streams bytes out
// Assumes: Requester supplies op, address and byte count; reads leave through a FIFO
// Notes: FIFO full stalls the bus clock between bytes, so bytes are never dropped
`timescale 1ns/10ps
module srs_fifo
#(
   parameter int W = 8,
   parameter int D = 8
)
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int PW = $clog2(D);
   logic [W-1:0] buf_ff [0:D-1];
   logic [PW:0] wp_ff, rp_ff;
   wire full = (wp_ff[PW-1:0] == rp_ff[PW-1:0]) && (wp_ff[PW] != rp_ff[PW]);
   wire empty = (wp_ff == rp_ff);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = buf_ff[rp_ff[PW-1:0]];
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         wp_ff <= '0;
         rp_ff <= '0;
      end
      else
      begin
         if (in_valid_i && !full)
         begin
            buf_ff[wp_ff[PW-1:0]] <= in_data_i;
            wp_ff <= wp_ff + 1'b1;
         end
         if (out_ready_i && !empty)
         begin
            rp_ff <= rp_ff + 1'b1;
         end
      end
   end
endmodule

module srs_master
   import srs_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Request
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire srs_pkg::srs_op_e req_op_i,
   input wire logic [srs_pkg::SRS_ADDR_W-1:0] req_addr_i,
   input wire logic [7:0] req_len_i,
   // Read data
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [7:0] rd_data_o,
   // Status
   output logic nak_o,
   // Link
   srs_link_if.master link
);
   import srs_pkg::*;

   typedef enum logic [3:0] {MS_IDLE, MS_START, MS_BYTE, MS_ACK, MS_RDB, MS_RACK, MS_RSTART, MS_STOP,
      MS_DONE} srs_ms_e;

   localparam int QW = $clog2(SRS_QTR_CYC + 1);

   srs_ms_e st_ff;
   logic [QW-1:0] q_ff;
   logic [1:0] ph_ff;
   logic [3:0] bit_ff;
   logic [1:0] idx_ff;
   logic [7:0] sh_ff;
   logic [7:0] left_ff;
   logic rd_ff;
   logic scl_ff;
   logic sda_ff;
   logic nak_ff;
   logic rdy_ff;
   logic [SRS_ADDR_W-1:0] adr_ff;
   logic push_ff;
   logic [7:0] pdat_ff;
   logic sda_m_ff, sda_s_ff;
   logic f_ready, f_valid;
   logic [7:0] f_data;

   wire tick = (q_ff == QW'(SRS_QTR_CYC - 1));
   wire [7:0] sel_rd = {SRS_SEL_CODE, SRS_DIR_READ};
   wire [7:0] sel_wr = {SRS_SEL_CODE, SRS_DIR_WRITE};
   wire more = (left_ff > 8'h1);

   srs_fifo #(.W(8), .D(SRS_FIFO_DEPTH)) u_fifo (
      .mclk_i(mclk_i), .resetn_i(resetn_i),
      .in_valid_i(push_ff), .in_ready_o(f_ready), .in_data_i(pdat_ff),
      .out_valid_o(f_valid), .out_ready_i(rd_ready_i), .out_data_o(f_data)
   );

   assign rd_valid_o = f_valid;
   assign rd_data_o = f_data;
   assign req_ready_o = rdy_ff;
   assign nak_o = nak_ff;
   assign link.scl_oe = !scl_ff;
   assign link.scl_out = 1'b0;
   assign link.m_sda_oe = !sda_ff;
   assign link.m_sda_out = 1'b0;

   always_ff @(posedge mclk_i)
   begin
      sda_m_ff <= link.sda;
      sda_s_ff <= sda_m_ff;
   end

   // Four phases per bit: low-set, rise, high-sample, fall
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         st_ff <= MS_IDLE;
         q_ff <= '0;
         ph_ff <= 2'h0;
         bit_ff <= 4'h0;
         idx_ff <= 2'h0;
         sh_ff <= 8'h00;
         left_ff <= 8'h00;
         rd_ff <= 1'b0;
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
         nak_ff <= 1'b0;
         rdy_ff <= 1'b0;
         adr_ff <= '0;
         push_ff <= 1'b0;
         pdat_ff <= 8'h00;
      end
      else
      begin
         push_ff <= 1'b0;
         q_ff <= tick ? '0 : q_ff + 1'b1;
         if (st_ff == MS_IDLE)
         begin
            rdy_ff <= 1'b1;
            if (req_valid_i && rdy_ff && req_op_i != SRS_OP_NONE)
            begin
               rdy_ff <= 1'b0;
               adr_ff <= req_addr_i;
               left_ff <= (req_len_i == 8'h00) ? 8'h01 : req_len_i;
               nak_ff <= 1'b0;
               rd_ff <= (req_op_i == SRS_OP_CUR); // R10
               st_ff <= MS_START;
               ph_ff <= 2'h0;
            end
         end
         else if (tick && !(st_ff == MS_RACK && ph_ff == 2'h0 && !f_ready))
         begin
            ph_ff <= ph_ff + 2'h1;
            case (st_ff)
               MS_START, MS_RSTART:
               begin
                  // Data high, clock high, data low: a (repeated) start
                  case (ph_ff)
                     2'h0: sda_ff <= 1'b1;
                     2'h1: scl_ff <= 1'b1;
                     2'h2: sda_ff <= 1'b0;
                     default:
                     begin
                        scl_ff <= 1'b0;
                        st_ff <= MS_BYTE;
                        bit_ff <= 4'h0;
                        idx_ff <= 2'h0;
                        sh_ff <= rd_ff ? sel_rd : sel_wr; // R5 R8
                     end
                  endcase
               end
               MS_BYTE:
               begin
                  case (ph_ff)
                     2'h0: sda_ff <= sh_ff[7]; // R16
                     2'h1: scl_ff <= 1'b1;
                     2'h2: sh_ff <= {sh_ff[6:0], 1'b0};
                     default:
                     begin
                        scl_ff <= 1'b0;
                        bit_ff <= bit_ff + 4'h1;
                        if (bit_ff == 4'(SRS_BIT_LAST))
                        begin
                           st_ff <= MS_ACK;
                        end
                     end
                  endcase
               end
               MS_ACK:
               begin
                  case (ph_ff)
                     2'h0: sda_ff <= 1'b1;
                     2'h1: scl_ff <= 1'b1;
                     2'h2: nak_ff <= sda_s_ff;
                     default:
                     begin
                        scl_ff <= 1'b0;
                        bit_ff <= 4'h0;
                        idx_ff <= idx_ff + 2'h1;
                        if (nak_ff)
                        begin
                           st_ff <= MS_STOP;
                        end
                        else if (rd_ff)
                        begin
                           st_ff <= MS_RDB;
                        end
                        else if (idx_ff == 2'h2)
                        begin
                           rd_ff <= 1'b1;
                           st_ff <= MS_RSTART; // R4 R5
                        end
                        else
                        begin
                           st_ff <= MS_BYTE; // R4
                           sh_ff <= (idx_ff == 2'h0) ? adr_ff[15:8] : adr_ff[7:0];
                        end
                     end
                  endcase
               end
               MS_RDB:
               begin
                  case (ph_ff)
                     2'h0: sda_ff <= 1'b1;
                     2'h1: scl_ff <= 1'b1;
                     2'h2: sh_ff <= {sh_ff[6:0], sda_s_ff};
                     default:
                     begin
                        scl_ff <= 1'b0;
                        bit_ff <= bit_ff + 4'h1;
                        if (bit_ff == 4'(SRS_BIT_LAST))
                        begin
                           st_ff <= MS_RACK;
                           push_ff <= 1'b1;
                           pdat_ff <= sh_ff;
                        end
                     end
                  endcase
               end
               MS_RACK:
               begin
                  case (ph_ff)
                     2'h0: sda_ff <= !more; // R7 R9 R12
                     2'h1: scl_ff <= 1'b1;
                     2'h2: left_ff <= left_ff - 8'h1;
                     default:
                     begin
                        scl_ff <= 1'b0;
                        bit_ff <= 4'h0;
                        st_ff <= (left_ff == 8'h0) ? MS_STOP : MS_RDB;
                     end
                  endcase
               end
               MS_STOP:
               begin
                  case (ph_ff)
                     2'h0: sda_ff <= 1'b0;
                     2'h1: scl_ff <= 1'b1;
                     2'h2: sda_ff <= 1'b1; // R7 R12
                     default: st_ff <= MS_DONE;
                  endcase
               end
               default:
               begin
                  st_ff <= MS_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// File: tb/srs_chk.sv
// Purpose: Wire-level checks on the two-wire link joining master and memory ends
// Assumes: Levels sampled on mclk_i, bus bits far slower than the clock
// Notes: Bits and bytes are tracked from the wires alone, never from either end's state
`timescale 1ns/10ps
module srs_chk
   import srs_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Link
   input wire logic scl_oe,
   input wire logic scl_out,
   input wire logic m_sda_oe,
   input wire logic m_sda_out,
   input wire logic s_sda_oe,
   input wire logic s_sda_out,
   input wire logic scl,
   input wire logic sda
);
   logic scl_q_ff, sda_q_ff, rd_ff, quiet_ff, wad_ff, rep_ff;
   logic [3:0] bit_ff;
   logic [1:0] byt_ff;
   logic [7:0] sh_ff;
   wire rise_w = scl && !scl_q_ff;
   wire start_w = scl && scl_q_ff && sda_q_ff && !sda;
   wire stop_w = scl && scl_q_ff && !sda_q_ff && sda;
   wire ack_w = rise_w && (bit_ff == 4'h8);
   wire first_w = (byt_ff == 2'h0);
   // Idle levels during reset so the first edge after release sees no false condition
   always_ff @(posedge mclk_i)
   begin
      scl_q_ff <= resetn_i ? scl : 1'b1;
      sda_q_ff <= resetn_i ? sda : 1'b1;
   end
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i || start_w)
      begin
         bit_ff <= 4'h0;
         byt_ff <= 2'h0;
      end
      else if (ack_w)
      begin
         bit_ff <= 4'h0;
         byt_ff <= (byt_ff == 2'h3) ? byt_ff : byt_ff + 2'h1;
      end
      else if (rise_w)
      begin
         bit_ff <= bit_ff + 4'h1;
         sh_ff <= {sh_ff[6:0], sda};
      end
   end
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i || stop_w)
      begin
         quiet_ff <= 1'b0;
         wad_ff <= 1'b0;
         rep_ff <= 1'b0;
         rd_ff <= 1'b0;
      end
      else if (start_w)
      begin
         quiet_ff <= 1'b0;
         wad_ff <= 1'b0;
         rep_ff <= wad_ff;
      end
      else if (ack_w)
      begin
         rd_ff <= first_w ? sh_ff[0] : rd_ff;
         quiet_ff <= quiet_ff || (sda && (first_w || rd_ff));
         wad_ff <= wad_ff || (!sda && !rd_ff && byt_ff == 2'h2);
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_start_seq;
      start_w;
   endsequence
   sequence s_low_seq;
      !scl;
   endsequence
   property p_start_clk;
      s_start_seq |-> ##[1:100] s_low_seq;
   endproperty
   sel_match_a: assert property (ack_w && first_w |-> sda == (sh_ff[7:1] != SRS_SEL_CODE))
      else $error("select acknowledge does not follow the code");
   addr_ack_a: assert property (ack_w && !first_w && !rd_ff |-> !sda)
      else $error("address byte not acknowledged");
   rd_release_a: assert property (ack_w && !first_w && rd_ff |-> !s_sda_oe)
      else $error("memory holds data line in acknowledge bit");
   erased_data_a: assert property (rise_w && rd_ff && !first_w && bit_ff < 4'h8 && !quiet_ff |-> sda)
      else $error("read bit not one");
   nak_quiet_a: assert property (quiet_ff |-> !s_sda_oe)
      else $error("memory drives after no acknowledge");
   stop_after_nak_a: assert property (start_w |-> !quiet_ff)
      else $error("start without stop after no acknowledge");
   no_stop_load_a: assert property (stop_w |-> !wad_ff)
      else $error("stop after address load");
   rep_read_a: assert property (ack_w && first_w && rep_ff |-> sh_ff[0] == SRS_DIR_READ)
      else $error("repeated start not a read select");
   mem_edge_a: assert property ($changed(s_sda_oe) |-> !scl)
      else $error("memory changes data line with clock high");
   start_clk_a: assert property (p_start_clk)
      else $error("no clock after start");
endmodule

// File: tb/test_serial_eeprom_read_sequencer.sv
// Purpose: Self-checking bench for master and memory ends joined by the link
// Assumes: 25 MHz clock, erased array, inputs driven at the falling edge
// Notes: A second memory on its own link is driven bit by bit to offer a foreign select code and its own read select
`timescale 1ns/10ps
module test_serial_eeprom_read_sequencer;
   import srs_pkg::*;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic req_valid_i = 1'b0;
   srs_op_e req_op_i = SRS_OP_CUR;
   logic [SRS_ADDR_W-1:0] req_addr_i = 16'h0000;
   logic [7:0] req_len_i = 8'h01;
   logic rd_ready_i = 1'b0;
   logic req_ready_o, rd_valid_o, nak_o, busy_o, busy_b;
   logic [7:0] rd_data_o, addr_o, addr_b;
   int bad_count = 0;
   int compares = 0;
   int n;
   srs_link_if link_if();
   srs_link_if link_b();
   always #20 mclk_i = ~mclk_i;
   srs_master u_srs_master (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_len_i(req_len_i),
      .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .nak_o(nak_o), .link(link_if));
   srs_mem u_srs_mem (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(link_if), .busy_o(busy_o), .addr_o(addr_o));
   srs_mem u_srs_mem_b (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(link_b), .busy_o(busy_b), .addr_o(addr_b));
   srs_chk u_srs_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .scl_oe(link_if.scl_oe), .scl_out(link_if.scl_out),
      .m_sda_oe(link_if.m_sda_oe), .m_sda_out(link_if.m_sda_out), .s_sda_oe(link_if.s_sda_oe),
      .s_sda_out(link_if.s_sda_out), .scl(link_if.scl), .sda(link_if.sda));
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic timeout(input string what);
      bad_count++;
      $display("CHECK FAILED %s expected done seen timeout", what);
      conclude();
   endtask
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp1(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic send_req(input srs_op_e op, input logic [15:0] addr, input logic [7:0] len);
      for (n = 0; req_ready_o !== 1'b1 && n < 20000; n++)
         @(negedge mclk_i);
      if (n >= 20000)
         timeout("request");
      req_op_i = op;
      req_addr_i = addr;
      req_len_i = len;
      req_valid_i = 1'b1;
      @(negedge mclk_i);
      req_valid_i = 1'b0;
   endtask
   // Extra edge on entry keeps rd_ready_i from being set twice in one time step
   task automatic pop_byte();
      @(negedge mclk_i);
      for (n = 0; rd_valid_o !== 1'b1 && n < 20000; n++)
         @(negedge mclk_i);
      if (n >= 20000)
         timeout("read data");
      cmp8("read data", SRS_ERASED, rd_data_o);
      rd_ready_i = 1'b1;
      @(negedge mclk_i);
      rd_ready_i = 1'b0;
   endtask
   task automatic wait_idle();
      for (n = 0; (req_ready_o !== 1'b1 || busy_o !== 1'b0) && n < 20000; n++)
         @(negedge mclk_i);
      if (n >= 20000)
         timeout("idle");
   endtask
   task automatic bb_bit(input logic b, output logic s);
      link_b.m_sda_oe = !b;
      repeat (SRS_QTR_CYC) @(negedge mclk_i);
      link_b.scl_oe = 1'b0;
      repeat (SRS_QTR_CYC) @(negedge mclk_i);
      s = link_b.sda;
      repeat (SRS_QTR_CYC) @(negedge mclk_i);
      link_b.scl_oe = 1'b1;
      repeat (SRS_QTR_CYC) @(negedge mclk_i);
   endtask
   task automatic bb_select(input logic [7:0] code, input logic exp_ack, input logic exp_busy);
      logic s;
      link_b.m_sda_oe = 1'b1;
      repeat (SRS_QTR_CYC) @(negedge mclk_i);
      link_b.scl_oe = 1'b1;
      for (int i = 7; i >= 0; i--)
         bb_bit(code[i], s);
      bb_bit(1'b1, s);
      cmp1("select acknowledge level", exp_ack, s);
      cmp1("memory selected", exp_busy, busy_b);
      bb_bit(1'b0, s);
      link_b.scl_oe = 1'b0;
      repeat (SRS_QTR_CYC) @(negedge mclk_i);
      link_b.m_sda_oe = 1'b0;
      repeat (4 * SRS_QTR_CYC) @(negedge mclk_i);
   endtask
   initial
   begin
      link_b.scl_oe = 1'b0;
      link_b.scl_out = 1'b0;
      link_b.m_sda_oe = 1'b0;
      link_b.m_sda_out = 1'b0;
      repeat (4) @(negedge mclk_i);
      resetn_i = 1'b1;
      // Upper address bits fall away in the 256-byte array
      send_req(SRS_OP_RAND, 16'h1234, 8'h01);
      pop_byte();
      wait_idle();
      cmp8("counter after random read", 8'h35, addr_o);
      cmp1("address nak", 1'b0, nak_o);
      $display("test random read done");
      send_req(SRS_OP_CUR, 16'h0000, 8'h00);
      pop_byte();
      wait_idle();
      cmp8("counter after current read", 8'h36, addr_o);
      cmp1("byte after no acknowledge", 1'b0, rd_valid_o);
      $display("test current read done");
      send_req(SRS_OP_RAND, 16'h00fe, 8'h04);
      repeat (4) pop_byte();
      wait_idle();
      cmp8("counter after wrap", 8'h02, addr_o);
      $display("test wrap read done");
      // Reader stalls: the bus clock must freeze once the buffer is full
      send_req(SRS_OP_RAND, 16'h0010, 8'h0a);
      for (n = 0; addr_o !== 8'h18 && n < 20000; n++)
         @(negedge mclk_i);
      if (n >= 20000)
         timeout("stream");
      repeat (1200) @(negedge mclk_i);
      cmp1("bus clock held", 1'b0, link_if.scl);
      cmp1("master busy", 1'b0, req_ready_o);
      repeat (10) pop_byte();
      wait_idle();
      cmp8("counter after stream", 8'h1a, addr_o);
      cmp1("buffer empty", 1'b0, rd_valid_o);
      $display("test stalled stream done");
      bb_select(8'haa, 1'b1, 1'b0);
      bb_select({SRS_SEL_CODE, SRS_DIR_READ}, 1'b0, 1'b1);
      cmp8("counter after cut read", 8'h00, addr_b);
      $display("test foreign select done");
      conclude();
   end
endmodule
